//--- src/hp_regs_pkg.sv
// shared constants, carrier types and helpers for the headphone level and routing registers
package hp_regs_pkg;

   // ****************************************************************
   // bus geometry
   // ****************************************************************
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // ****************************************************************
   // register indices; byte address is four times the index
   // ****************************************************************
   localparam logic [7:0] IDX_LEFT_COMMON_OUT_LEVEL_CTRL = 8'h3a;
   localparam logic [7:0] IDX_RESERVED_SLOT_A = 8'h3b;
   localparam logic [7:0] IDX_LEFT_AMP_TO_RIGHT_HP_VOL = 8'h3c;
   localparam logic [7:0] IDX_LEFT_CONV_TO_RIGHT_HP_VOL = 8'h3d;
   localparam logic [7:0] IDX_RESERVED_SLOT_B = 8'h3e;
   localparam logic [7:0] IDX_RIGHT_AMP_TO_RIGHT_HP_VOL = 8'h3f;
   localparam logic [7:0] IDX_RIGHT_CONV_TO_RIGHT_HP_VOL = 8'h40;
   localparam logic [7:0] IDX_RIGHT_HP_OUT_LEVEL_CTRL = 8'h41;
   localparam logic [7:0] IDX_RESERVED_SLOT_C = 8'h42;
   localparam logic [7:0] IDX_LEFT_AMP_TO_RIGHT_COMMON_VOL = 8'h43;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h60;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h61;

   // ****************************************************************
   // field positions and reset values
   // ****************************************************************
   localparam int LEVEL_MSB = 7;
   localparam int LEVEL_LSB = 4;
   localparam int MUTE_BIT = 3;
   localparam int DRIVE_BIT = 2;
   localparam int PEND_BIT = 1;
   localparam int POWER_BIT = 0;
   localparam int ROUTE_BIT = 7;
   localparam logic [7:0] LEVEL_REG_RESET = 8'h04;
   localparam logic [7:0] LEVEL_STORE_MASK = 8'hfd;
   localparam logic [7:0] ROUTE_REG_RESET = 8'h00;
   localparam logic PEND_RESET = 1'b1;
   localparam logic [3:0] LEVEL_MAX_CODE = 4'h9;

   // interrupt status and mask bits
   localparam int IRQ_W = 2;
   localparam int IRQ_LCOM_DONE = 0;
   localparam int IRQ_RHP_DONE = 1;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

   // ****************************************************************
   // timing: one gain code step per interval
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 4;
   localparam int GAIN_STEP_NS = 40;
   localparam logic [7:0] GAIN_STEP_CYCLES =
      8'((GAIN_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ****************************************************************
   // carrier types
   // ****************************************************************
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } apb_req_type;

   typedef struct packed {
      logic pready;
      logic [DATA_W-1:0] prdata;
      logic pslverr;
   } apb_rsp_type;

   typedef struct packed {
      logic [3:0] level;
      logic unmute;
      logic hiZ;
      logic powerUp;
   } out_ctrl_type;

   typedef struct packed {
      logic enable;
      logic [6:0] volume;
   } route_type;

   typedef struct packed {
      logic [3:0] level;
      logic [3:0][6:0] volume;
   } gain_target_type;

   // moves a gain code one step toward its programmed value
   function automatic logic [6:0] stepToward(input logic [6:0] cur, input logic [6:0] tgt);
      if (cur < tgt)
      begin
         return 7'(cur + 7'h01);
      end
      else if (cur > tgt)
      begin
         return 7'(cur - 7'h01);
      end
      return cur;
   endfunction

endpackage

//--- src/gain_step_tracker.sv
// walks applied gains toward programmed gains and reports while any is still pending
`timescale 1ns/1ns
`default_nettype none

module gain_step_tracker
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire hp_regs_pkg::gain_target_type target,
   output var hp_regs_pkg::gain_target_type applied,
   output var logic pending,
   output var logic doneEvent
);

   typedef struct packed {
      hp_regs_pkg::gain_target_type applied;
      logic [7:0] timer;
      logic pending;
      logic done;
   } state_type;

   state_type s_reg;
   state_type s_next;

   // ****************************************************************
   // stepping: gradual changes avoid audible clicks on the driver
   // ****************************************************************
   always_comb
   begin
      s_next = s_reg;
      s_next.done = 1'b0;
      if (s_reg.timer == 8'h00)
      begin
         s_next.timer = 8'(hp_regs_pkg::GAIN_STEP_CYCLES - 8'h01);
         s_next.applied.level = 4'(hp_regs_pkg::stepToward({3'h0, s_reg.applied.level},
            {3'h0, target.level}));
         for (int i = 0; i < 4; i++)
         begin
            s_next.applied.volume[i] = hp_regs_pkg::stepToward(s_reg.applied.volume[i],
               target.volume[i]);
         end
         s_next.pending = (s_next.applied != target);
      end
      else
      begin
         s_next.timer = 8'(s_reg.timer - 8'h01);
         s_next.pending = (s_reg.applied != target);
      end
      s_next.done = s_reg.pending & ~s_next.pending;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         s_reg <= '{applied: '0, timer: 8'h00, pending: hp_regs_pkg::PEND_RESET, done: 1'b0};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign applied = s_reg.applied;
   assign pending = s_reg.pending;
   assign doneEvent = s_reg.done;

   a_pending_meaning: assert property (@(posedge clk_sys) disable iff (rst)
      (s_reg.timer != 8'h00) |=> (pending == ($past(s_reg.applied) != $past(target))))
      else $error("pending flag does not follow applied versus programmed gains");

endmodule // gain_step_tracker

`default_nettype wire

//--- src/headphone_output_route_level_regs.sv
// APB register slice for headphone output levels, mutes, power and routing volumes
//
// How it works
// - each output level register keeps a 4-bit level in bits 7..4, codes 0..9 mean 0..9 dB, reset 0.
// - bit 3 unmutes the output when one; it resets to zero so outputs start muted.
// - bit 2 picks high impedance (one) or weak common-mode drive (zero) when down; reset one.
// - bit 1 is read-only and reads one while programmed gains are still being applied; reset one.
// - bit 0 powers the driver fully up when one; reset zero.
// - the left common output level sits at index 58 and the right headphone level at 65.
// - bit 7 of each routing register connects its source to its output when one; reset zero.
// - bits 6..0 of each routing register hold a 7-bit path volume, reset zero.
// - right headphone routing sits at 60, 61, 63 and 64 for the four sources.
// - index 67 routes the left input amplifier to the right common output.
`timescale 1ns/1ns
`default_nettype none

module headphone_output_route_level_regs
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire hp_regs_pkg::apb_req_type apbReq,
   output var hp_regs_pkg::apb_rsp_type apbRsp,
   output var hp_regs_pkg::out_ctrl_type leftCommonOut,
   output var hp_regs_pkg::out_ctrl_type rightHpOut,
   output var hp_regs_pkg::route_type [3:0] rightHpRoute,
   output var hp_regs_pkg::route_type rightCommonRoute,
   output var logic irq
);

   typedef struct packed {
      logic [7:0] lcomLevel;
      logic [7:0] rhpLevel;
      logic [3:0][7:0] rhpVol;
      logic [7:0] rcomVol;
      logic [hp_regs_pkg::IRQ_W-1:0] irqStatus;
      logic [hp_regs_pkg::IRQ_W-1:0] irqMask;
      hp_regs_pkg::apb_rsp_type rsp;
      logic irq;
      hp_regs_pkg::out_ctrl_type lcomOut;
      hp_regs_pkg::out_ctrl_type rhpOut;
      hp_regs_pkg::route_type [3:0] rhpRoute;
      hp_regs_pkg::route_type rcomRoute;
   } state_type;

   state_type s_reg;
   state_type s_next;

   hp_regs_pkg::gain_target_type lcomTarget;
   hp_regs_pkg::gain_target_type rhpTarget;
   hp_regs_pkg::gain_target_type lcomApplied;
   hp_regs_pkg::gain_target_type rhpApplied;
   logic lcomPending;
   logic rhpPending;
   logic lcomDone;
   logic rhpDone;
   logic [7:0] idx;
   logic aligned;
   logic accessStart;
   logic writeDone;

   // ****************************************************************
   // decode helpers
   // ****************************************************************
   function automatic logic isMapped(input logic [7:0] i);
      case (i)
         hp_regs_pkg::IDX_LEFT_COMMON_OUT_LEVEL_CTRL,
         hp_regs_pkg::IDX_RESERVED_SLOT_A,
         hp_regs_pkg::IDX_LEFT_AMP_TO_RIGHT_HP_VOL,
         hp_regs_pkg::IDX_LEFT_CONV_TO_RIGHT_HP_VOL,
         hp_regs_pkg::IDX_RESERVED_SLOT_B,
         hp_regs_pkg::IDX_RIGHT_AMP_TO_RIGHT_HP_VOL,
         hp_regs_pkg::IDX_RIGHT_CONV_TO_RIGHT_HP_VOL,
         hp_regs_pkg::IDX_RIGHT_HP_OUT_LEVEL_CTRL,
         hp_regs_pkg::IDX_RESERVED_SLOT_C,
         hp_regs_pkg::IDX_LEFT_AMP_TO_RIGHT_COMMON_VOL,
         hp_regs_pkg::IDX_IRQ_STATUS,
         hp_regs_pkg::IDX_IRQ_MASK: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // stored level registers never hold the status bit; it is merged on read
   function automatic logic [7:0] levelView(input logic [7:0] stored, input logic pend);
      logic [7:0] v;
      v = stored & hp_regs_pkg::LEVEL_STORE_MASK;
      v[hp_regs_pkg::PEND_BIT] = pend;
      return v;
   endfunction

   function automatic hp_regs_pkg::out_ctrl_type outCtrl(input logic [7:0] stored,
      input logic [3:0] appliedLevel);
      hp_regs_pkg::out_ctrl_type o;
      o.level = appliedLevel;
      o.unmute = stored[hp_regs_pkg::MUTE_BIT];
      o.hiZ = stored[hp_regs_pkg::DRIVE_BIT];
      o.powerUp = stored[hp_regs_pkg::POWER_BIT];
      return o;
   endfunction

   assign idx = apbReq.paddr[9:2];
   assign aligned = (apbReq.paddr[1:0] == 2'h0) && (apbReq.paddr[11:10] == 2'h0);
   // one wait state: pready comes from a flop and the write lands on the closing edge
   assign accessStart = apbReq.psel & apbReq.penable & ~s_reg.rsp.pready;
   assign writeDone = apbReq.psel & apbReq.penable & s_reg.rsp.pready & apbReq.pwrite;

   // ****************************************************************
   // gain tracking per output
   // ****************************************************************
   always_comb
   begin
      lcomTarget = '0;
      lcomTarget.level = s_reg.lcomLevel[hp_regs_pkg::LEVEL_MSB:hp_regs_pkg::LEVEL_LSB];
      rhpTarget = '0;
      rhpTarget.level = s_reg.rhpLevel[hp_regs_pkg::LEVEL_MSB:hp_regs_pkg::LEVEL_LSB];
      for (int i = 0; i < 4; i++)
      begin
         rhpTarget.volume[i] = s_reg.rhpVol[i][6:0];
      end
   end

   gain_step_tracker lcomTracker
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .target(lcomTarget),
      .applied(lcomApplied),
      .pending(lcomPending),
      .doneEvent(lcomDone)
   );

   gain_step_tracker rhpTracker
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .target(rhpTarget),
      .applied(rhpApplied),
      .pending(rhpPending),
      .doneEvent(rhpDone)
   );

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb
   begin
      logic [7:0] rd;
      logic [7:0] wd;
      logic [hp_regs_pkg::IRQ_W-1:0] clearBits;
      rd = 8'h00;
      wd = apbReq.pwdata[7:0];
      clearBits = '0;
      s_next = s_reg;

      // read view; reserved slots read zero
      case (idx)
         hp_regs_pkg::IDX_LEFT_COMMON_OUT_LEVEL_CTRL: rd = levelView(s_reg.lcomLevel,
            lcomPending);
         hp_regs_pkg::IDX_RIGHT_HP_OUT_LEVEL_CTRL: rd = levelView(s_reg.rhpLevel,
            rhpPending);
         hp_regs_pkg::IDX_LEFT_AMP_TO_RIGHT_HP_VOL: rd = s_reg.rhpVol[0];
         hp_regs_pkg::IDX_LEFT_CONV_TO_RIGHT_HP_VOL: rd = s_reg.rhpVol[1];
         hp_regs_pkg::IDX_RIGHT_AMP_TO_RIGHT_HP_VOL: rd = s_reg.rhpVol[2];
         hp_regs_pkg::IDX_RIGHT_CONV_TO_RIGHT_HP_VOL: rd = s_reg.rhpVol[3];
         hp_regs_pkg::IDX_LEFT_AMP_TO_RIGHT_COMMON_VOL: rd = s_reg.rcomVol;
         hp_regs_pkg::IDX_IRQ_STATUS: rd = {6'h00, s_reg.irqStatus};
         hp_regs_pkg::IDX_IRQ_MASK: rd = {6'h00, s_reg.irqMask};
         default: rd = 8'h00;
      endcase

      // bus answer
      s_next.rsp.pready = accessStart;
      if (accessStart)
      begin
         s_next.rsp.prdata = {24'h000000, rd};
         s_next.rsp.pslverr = ~(aligned && isMapped(idx));
      end
      else if (s_reg.rsp.pready)
      begin
         s_next.rsp.prdata = '0;
         s_next.rsp.pslverr = 1'b0;
      end

      // writes land on the edge that closes the access
      if (writeDone && aligned)
      begin
         case (idx)
            hp_regs_pkg::IDX_LEFT_COMMON_OUT_LEVEL_CTRL:
               s_next.lcomLevel = wd & hp_regs_pkg::LEVEL_STORE_MASK;
            hp_regs_pkg::IDX_RIGHT_HP_OUT_LEVEL_CTRL:
               s_next.rhpLevel = wd & hp_regs_pkg::LEVEL_STORE_MASK;
            hp_regs_pkg::IDX_LEFT_AMP_TO_RIGHT_HP_VOL: s_next.rhpVol[0] = wd;
            hp_regs_pkg::IDX_LEFT_CONV_TO_RIGHT_HP_VOL: s_next.rhpVol[1] = wd;
            hp_regs_pkg::IDX_RIGHT_AMP_TO_RIGHT_HP_VOL: s_next.rhpVol[2] = wd;
            hp_regs_pkg::IDX_RIGHT_CONV_TO_RIGHT_HP_VOL: s_next.rhpVol[3] = wd;
            hp_regs_pkg::IDX_LEFT_AMP_TO_RIGHT_COMMON_VOL: s_next.rcomVol = wd;
            hp_regs_pkg::IDX_IRQ_STATUS: clearBits = wd[hp_regs_pkg::IRQ_W-1:0];
            hp_regs_pkg::IDX_IRQ_MASK: s_next.irqMask = wd[hp_regs_pkg::IRQ_W-1:0];
            default: s_next.irqMask = s_reg.irqMask;
         endcase
      end

      // sticky events: a completion in the clearing cycle survives the clear
      s_next.irqStatus = s_reg.irqStatus & ~clearBits;
      s_next.irqStatus[hp_regs_pkg::IRQ_LCOM_DONE] = s_next.irqStatus[hp_regs_pkg::IRQ_LCOM_DONE]
         | lcomDone;
      s_next.irqStatus[hp_regs_pkg::IRQ_RHP_DONE] = s_next.irqStatus[hp_regs_pkg::IRQ_RHP_DONE]
         | rhpDone;
      s_next.irq = |(s_next.irqStatus & s_next.irqMask);

      // analog controls; the level code applied is the stepped one
      s_next.lcomOut = outCtrl(s_reg.lcomLevel, lcomApplied.level);
      s_next.rhpOut = outCtrl(s_reg.rhpLevel, rhpApplied.level);
      for (int i = 0; i < 4; i++)
      begin
         s_next.rhpRoute[i].enable = s_reg.rhpVol[i][hp_regs_pkg::ROUTE_BIT];
         s_next.rhpRoute[i].volume = rhpApplied.volume[i];
      end
      s_next.rcomRoute.enable = s_reg.rcomVol[hp_regs_pkg::ROUTE_BIT];
      s_next.rcomRoute.volume = s_reg.rcomVol[6:0];
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         s_reg <= '0;
         s_reg.lcomLevel <= hp_regs_pkg::LEVEL_REG_RESET;
         s_reg.rhpLevel <= hp_regs_pkg::LEVEL_REG_RESET;
         s_reg.rhpVol <= {4{hp_regs_pkg::ROUTE_REG_RESET}};
         s_reg.rcomVol <= hp_regs_pkg::ROUTE_REG_RESET;
         s_reg.irqStatus <= hp_regs_pkg::IRQ_RESET;
         s_reg.irqMask <= hp_regs_pkg::IRQ_RESET;
         s_reg.lcomOut.hiZ <= 1'b1;
         s_reg.rhpOut.hiZ <= 1'b1;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign apbRsp = s_reg.rsp;
   assign leftCommonOut = s_reg.lcomOut;
   assign rightHpOut = s_reg.rhpOut;
   assign rightHpRoute = s_reg.rhpRoute;
   assign rightCommonRoute = s_reg.rcomRoute;
   assign irq = s_reg.irq;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_level_field_store: assert property (
      writeDone && aligned && idx == hp_regs_pkg::IDX_LEFT_COMMON_OUT_LEVEL_CTRL
      |=> s_reg.lcomLevel[7:4] == $past(apbReq.pwdata[7:4]))
      else $error("level field not stored");

   a_mute_reaches_out: assert property (
      writeDone && aligned && idx == hp_regs_pkg::IDX_RIGHT_HP_OUT_LEVEL_CTRL
      |=> ##1 rightHpOut.unmute == $past(apbReq.pwdata[3], 2))
      else $error("mute control not reflected on right output");

   a_drive_after_reset: assert property (disable iff (1'b0)
      rst ##1 !rst |-> leftCommonOut.hiZ && rightHpOut.hiZ && s_reg.lcomLevel[2])
      else $error("power-down drive not high impedance after reset");

   a_pending_read: assert property (
      accessStart && !apbReq.pwrite && aligned && idx == hp_regs_pkg::IDX_RIGHT_HP_OUT_LEVEL_CTRL
      |=> apbRsp.pready && apbRsp.prdata[1] == $past(rhpPending))
      else $error("status bit does not show pending gains");

   a_power_reaches_out: assert property (
      writeDone && aligned && idx == hp_regs_pkg::IDX_LEFT_COMMON_OUT_LEVEL_CTRL
      |=> ##1 leftCommonOut.powerUp == $past(apbReq.pwdata[0], 2))
      else $error("power control not reflected on left common output");

   a_route_enable_out: assert property (
      writeDone && aligned && idx == hp_regs_pkg::IDX_LEFT_AMP_TO_RIGHT_HP_VOL
      |=> ##1 rightHpRoute[0].enable == $past(apbReq.pwdata[7], 2))
      else $error("routing enable not applied");

   a_route_volume_store: assert property (
      writeDone && aligned && idx == hp_regs_pkg::IDX_RIGHT_CONV_TO_RIGHT_HP_VOL
      |=> s_reg.rhpVol[3][6:0] == $past(apbReq.pwdata[6:0]))
      else $error("routing volume not stored");

   a_common_route_out: assert property (
      writeDone && aligned && idx == hp_regs_pkg::IDX_LEFT_AMP_TO_RIGHT_COMMON_VOL
      |=> ##1 rightCommonRoute == $past(apbReq.pwdata[7:0], 2))
      else $error("right common routing not applied");

   a_read_back: assert property (
      accessStart && !apbReq.pwrite && aligned && idx == hp_regs_pkg::IDX_LEFT_CONV_TO_RIGHT_HP_VOL
      |=> apbRsp.prdata[7:0] == $past(s_reg.rhpVol[1]))
      else $error("read back differs from stored value");

   a_reserved_reads_zero: assert property (
      accessStart && aligned && idx == hp_regs_pkg::IDX_RESERVED_SLOT_B
      |=> apbRsp.prdata == '0 && !apbRsp.pslverr)
      else $error("reserved slot does not read zero");

   a_level_right_store: assert property (
      writeDone && aligned && idx == hp_regs_pkg::IDX_RIGHT_HP_OUT_LEVEL_CTRL
      |=> s_reg.rhpLevel[7:4] == $past(apbReq.pwdata[7:4]))
      else $error("right level field not stored");

   a_drive_reaches_out: assert property (
      writeDone && aligned && idx == hp_regs_pkg::IDX_LEFT_COMMON_OUT_LEVEL_CTRL
      |=> ##1 leftCommonOut.hiZ == $past(apbReq.pwdata[2], 2))
      else $error("power-down drive choice not reflected on left common output");

   a_pending_left_read: assert property (
      accessStart && !apbReq.pwrite && aligned
      && idx == hp_regs_pkg::IDX_LEFT_COMMON_OUT_LEVEL_CTRL
      |=> apbRsp.prdata[1] == $past(lcomPending))
      else $error("left status bit does not show pending gains");

   a_pending_at_reset: assert property (disable iff (1'b0)
      rst ##1 !rst |-> lcomPending && rhpPending)
      else $error("status bits do not start as pending");

   a_route_right_amp: assert property (
      writeDone && aligned && idx == hp_regs_pkg::IDX_RIGHT_AMP_TO_RIGHT_HP_VOL
      |=> ##1 rightHpRoute[2].enable == $past(apbReq.pwdata[7], 2))
      else $error("right amplifier routing enable not applied");

   a_reserved_c_zero: assert property (
      accessStart && aligned && idx == hp_regs_pkg::IDX_RESERVED_SLOT_C
      |=> apbRsp.prdata == '0 && !apbRsp.pslverr)
      else $error("last reserved slot does not read zero");

   c_level_write: cover property (writeDone && idx == hp_regs_pkg::IDX_RIGHT_HP_OUT_LEVEL_CTRL);
   c_gains_settle: cover property ($fell(rhpPending));
   c_irq_raised: cover property ($rose(irq));
   c_pending_read: cover property (accessStart && lcomPending
      && idx == hp_regs_pkg::IDX_LEFT_COMMON_OUT_LEVEL_CTRL);

endmodule // headphone_output_route_level_regs

`default_nettype wire

//--- tb/apb_host_model.sv
// APB host model standing in for the control software on the register port
`timescale 1ns/1ns
`default_nettype none

module apb_host_model
(
   input wire logic clk_sys,
   input wire hp_regs_pkg::apb_rsp_type apbRsp,
   output var hp_regs_pkg::apb_req_type apbReq
);
   initial
   begin
      apbReq = '0;
   end

   // one access: setup, then access held until pready; hung set if none within 20 edges
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
      output logic [7:0] rd, output logic err, output logic hung);
      int n;
      n = 0;
      @(posedge clk_sys);
      apbReq.psel <= 1'b1;
      apbReq.penable <= 1'b0;
      apbReq.pwrite <= wr;
      apbReq.paddr <= {2'b00, idx, 2'b00};
      apbReq.pwdata <= {24'h000000, wd};
      @(posedge clk_sys);
      apbReq.penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (apbRsp.pready !== 1'b1 && n < 20);
      hung = (apbRsp.pready !== 1'b1);
      rd = apbRsp.prdata[7:0];
      err = apbRsp.pslverr;
      // released lines show no stale value
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      apbReq.pwrite <= ~wr;
      apbReq.paddr <= ~apbReq.paddr;
      apbReq.pwdata <= ~apbReq.pwdata;
   endtask
endmodule // apb_host_model
`default_nettype wire

//--- tb/headphone_output_route_level_regs_bench.sv
// self-checking bench for the headphone level and routing register slice
`timescale 1ns/1ns
`default_nettype none

module headphone_output_route_level_regs_bench;
   localparam int LIMIT = 20000;
   logic clk_sys, rst, irq, rdErr;
   logic [7:0] rdData, wd;
   logic [31:0] seed = 32'he9ce85a4;
   int nFail = 0, numChecks = 0, cycles = 0;
   hp_regs_pkg::apb_req_type apbReq;
   hp_regs_pkg::apb_rsp_type apbRsp;
   hp_regs_pkg::out_ctrl_type leftCommonOut, rightHpOut;
   hp_regs_pkg::route_type [3:0] rightHpRoute;
   hp_regs_pkg::route_type rightCommonRoute;
   logic [7:0] routeIdx [5] = '{8'h3c, 8'h3d, 8'h3f, 8'h40, 8'h43};
   logic [7:0] lvlIdx [2] = '{8'h3a, 8'h41};
   logic [7:0] last [5];

   headphone_output_route_level_regs u_headphone_output_route_level_regs (.clk_sys(clk_sys),
      .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp), .leftCommonOut(leftCommonOut),
      .rightHpOut(rightHpOut), .rightHpRoute(rightHpRoute),
      .rightCommonRoute(rightCommonRoute), .irq(irq));
   apb_host_model u_apb_host_model (.clk_sys(clk_sys), .apbRsp(apbRsp), .apbReq(apbReq));

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // settled read value: pending bit clear, the rest as written
   function automatic logic [7:0] expLvl(input logic [7:0] v);
      return v & hp_regs_pkg::LEVEL_STORE_MASK;
   endfunction

   function automatic hp_regs_pkg::out_ctrl_type expOut(input logic [7:0] v);
      return '{level: v[7:4], unmute: v[3], hiZ: v[2], powerUp: v[0]};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      numChecks++;
      if (got !== exp)
      begin
         nFail++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic acc(input logic wr, input logic [7:0] idx, input logic [7:0] v);
      logic hung;
      u_apb_host_model.xfer(wr, idx, v, rdData, rdErr, hung);
      if (hung)
      begin
         nFail++;
         $display("unexpected at %0t: no pready at index %h", $time, idx);
      end
   endtask

   task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input logic expErr);
      acc(1'b0, idx, 8'h00);
      chk({23'h0, rdErr, rdData}, {23'h0, expErr, exp}, "read");
   endtask

   task automatic end_sim();
      $display("checks %0d, mismatches %0d", numChecks, nFail);
      if (nFail == 0 && numChecks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         nFail++;
         end_sim();
      end
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial
   begin
      rst = 1'b1;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (5) @(posedge clk_sys);
      for (int i = 8'h3a; i <= 8'h43; i++)
         rdchk(8'(i), (i == 8'h3a || i == 8'h41) ? 8'h04 : 8'h00, 1'b0);
      chk(32'(leftCommonOut), 32'(expOut(8'h04)), "left reset");
      chk(32'(rightHpOut), 32'(expOut(8'h04)), "right reset");
      $display("reset values done");

      for (int r = 0; r < 3; r++)
         foreach (routeIdx[k])
         begin
            wd = 8'(xs());
            last[k] = wd;
            acc(1'b1, routeIdx[k], wd);
            rdchk(routeIdx[k], wd, 1'b0);
            if (k == 4)
               chk(32'(rightCommonRoute), 32'(wd), "common route");
            else
               chk(32'(rightHpRoute[k].enable), 32'(wd[7]), "route enable");
         end
      // worst case is 127 volume steps of ten cycles each
      repeat (1400) @(posedge clk_sys);
      for (int k = 0; k < 4; k++)
         chk(32'(rightHpRoute[k].volume), 32'(last[k][6:0]), "route volume");
      $display("routing done");

      acc(1'b1, hp_regs_pkg::IDX_IRQ_STATUS, 8'h03);
      acc(1'b1, hp_regs_pkg::IDX_IRQ_MASK, 8'h03);
      foreach (lvlIdx[j])
         for (int i = 0; i < 2; i++)
         begin
            wd = 8'(xs());
            wd[7:4] = (i == 0) ? hp_regs_pkg::LEVEL_MAX_CODE : 4'(wd % 10);
            acc(1'b1, lvlIdx[j], wd);
            if (i == 0)
               rdchk(lvlIdx[j], expLvl(wd) | 8'h02, 1'b0);
            repeat (110) @(posedge clk_sys);
            rdchk(lvlIdx[j], expLvl(wd), 1'b0);
            chk(32'((j == 0) ? leftCommonOut : rightHpOut), 32'(expOut(wd)), "out");
         end
      $display("levels done");

      rdchk(hp_regs_pkg::IDX_IRQ_STATUS, 8'h03, 1'b0);
      chk(32'(irq), 32'(1), "irq raised");
      acc(1'b1, hp_regs_pkg::IDX_IRQ_MASK, 8'h00);
      rdchk(hp_regs_pkg::IDX_IRQ_MASK, 8'h00, 1'b0);
      chk(32'(irq), 32'(0), "irq masked");
      acc(1'b1, hp_regs_pkg::IDX_IRQ_MASK, 8'h03);
      acc(1'b1, hp_regs_pkg::IDX_IRQ_STATUS, 8'h01);
      rdchk(hp_regs_pkg::IDX_IRQ_STATUS, 8'h02, 1'b0);
      chk(32'(irq), 32'(1), "irq partly cleared");
      acc(1'b1, hp_regs_pkg::IDX_IRQ_STATUS, 8'h02);
      rdchk(hp_regs_pkg::IDX_IRQ_STATUS, 8'h00, 1'b0);
      chk(32'(irq), 32'(0), "irq cleared");
      $display("interrupt done");

      // reserved slots are never written by software; they must still read zero
      foreach (lvlIdx[j])
         rdchk(lvlIdx[j] + 8'h01, 8'h00, 1'b0);
      rdchk(hp_regs_pkg::IDX_RESERVED_SLOT_B, 8'h00, 1'b0);
      acc(1'b1, 8'h50, 8'hff);
      chk(32'(rdErr), 32'(1), "unmapped write");
      rdchk(8'h50, 8'h00, 1'b1);
      $display("reserved and unmapped done");
      end_sim();
   end
endmodule // headphone_output_route_level_regs_bench
`default_nettype wire
